// [ioex_pkg.sv]
`timescale 1ns/1ps
package ioex_pkg;
    // ****************************************
    // Framing constants
    // ****************************************
    localparam int PORT_W = 8;
    localparam int SEL_W = 3;
    localparam int HIGH_W = 4;
    localparam int BUF_DEPTH = 2;
    localparam logic [3:0] BIT_ZERO = 4'h0;
    localparam logic [3:0] BIT_ONE = 4'h1;
    localparam logic [3:0] BYTE_DONE = 4'h8;
    localparam int MSB = 7;
    localparam int RW_BIT = 0;
    localparam int SEL_LSB = 1;
    localparam int SEL_MSB = 3;
    localparam int HIGH_LSB = 4;
    localparam logic [7:0] LATCH_RST = 8'h00;
    localparam int SYNC_W = 13;
    localparam int SYN_SCL = 12;
    localparam int SYN_SDA = 11;
    localparam int SYN_SEL_LSB = 8;

    // ****************************************
    // Serial engine states
    // ****************************************
    typedef enum logic [5:0] {
        ST_IDLE = 6'b00_0001,
        ST_ADDR = 6'b00_0010,
        ST_WRITE = 6'b00_0100,
        ST_READ = 6'b00_1000,
        ST_ACK = 6'b01_0000,
        ST_MACK = 6'b10_0000
    } ioex_state_t;
endpackage : ioex_pkg

// ****************************************
// Two-entry byte buffer
// ****************************************
module ioex_pair_buf
    import ioex_pkg::*;
(
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [PORT_W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [PORT_W-1:0] out_data
);
    logic [PORT_W-1:0] mem [BUF_DEPTH];
    logic wr_ptr;
    logic rd_ptr;
    logic [1:0] count;
    logic push;
    logic pop;

    assign in_ready = (count != 2'h2);
    assign out_valid = (count != 2'h0);
    assign out_data = mem[rd_ptr];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            mem[0] <= LATCH_RST;
            mem[1] <= LATCH_RST;
        end else if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
        end else begin
            if (push) begin
                wr_ptr <= ~wr_ptr;
            end
            if (pop) begin
                rd_ptr <= ~rd_ptr;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            count <= 2'h0;
        end else begin
            case ({push, pop})
                2'b10: count <= count + 2'h1;
                2'b01: count <= count - 2'h1;
                default: count <= count;
            endcase
        end
    end
endmodule : ioex_pair_buf

// [ioex_expander.sv]
`timescale 1ns/1ps
module ioex_expander
    import ioex_pkg::*;
#(
    parameter logic [HIGH_W-1:0] ADDR_HIGH = 4'h4 // Arbitrary fixed address part
)(
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic addr_select_pin_0,
    input wire logic addr_select_pin_1,
    input wire logic addr_select_pin_2,
    input wire logic [PORT_W-1:0] port_pin_in,
    output logic [PORT_W-1:0] port_pin_out,
    output logic [PORT_W-1:0] port_pin_oe,
    input wire logic latch_hold,
    output logic [PORT_W-1:0] dir_latch,
    output logic [PORT_W-1:0] in_latch,
    output logic busy
);
    // ****************************************
    // Declarations
    // ****************************************
    logic [SYNC_W-1:0] sync1;
    logic [SYNC_W-1:0] sync2;
    logic scl_d;
    logic sda_d;
    logic scl_s;
    logic sda_s;
    logic [SEL_W-1:0] sel_s;
    logic [PORT_W-1:0] pin_s;
    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;
    ioex_state_t state;
    logic [3:0] bit_cnt;
    logic [PORT_W-1:0] rx_shift;
    logic [PORT_W-1:0] tx_shift;
    logic read_mode;
    logic first_byte;
    logic master_ack;
    logic addr_match;
    logic byte_end;
    logic dir_load;
    logic data_push;
    logic sample_now;
    logic [PORT_W-1:0] pin_view;
    logic [PORT_W-1:0] out_latch;
    logic buf_in_ready;
    logic buf_out_valid;
    logic buf_out_ready;
    logic [PORT_W-1:0] buf_out_data;

    // ****************************************
    // Input synchronisers
    // ****************************************
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            sync1 <= 13'h1_800;
            sync2 <= 13'h1_800;
        end else begin
            sync1 <= {scl_in, sda_in, addr_select_pin_2, addr_select_pin_1, addr_select_pin_0, port_pin_in};
            sync2 <= sync1;
        end
    end

    assign scl_s = sync2[SYN_SCL];
    assign sda_s = sync2[SYN_SDA];
    assign sel_s = sync2[SYN_SEL_LSB +: SEL_W];
    assign pin_s = sync2[PORT_W-1:0];

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_d <= scl_s;
            sda_d <= sda_s;
        end
    end

    // ****************************************
    // Bus conditions
    // ****************************************
    assign scl_rise = scl_s && !scl_d;
    assign scl_fall = !scl_s && scl_d;
    assign start_cond = scl_s && scl_d && sda_d && !sda_s;
    assign stop_cond = scl_s && scl_d && !sda_d && sda_s;
    assign byte_end = scl_fall && (bit_cnt == BYTE_DONE);
    assign addr_match = (rx_shift[SEL_MSB:SEL_LSB] == sel_s)
        && (rx_shift[MSB:HIGH_LSB] == ADDR_HIGH);

    // ****************************************
    // Port view seen by the input latch
    // ****************************************
    genvar gi;
    generate
        for (gi = 0; gi < PORT_W; gi++) begin : g_view
            assign pin_view[gi] = dir_latch[gi] ? out_latch[gi] : pin_s[gi];
        end
    endgenerate

    // ****************************************
    // Serial engine
    // ****************************************
    assign dir_load = (state == ST_WRITE) && byte_end && first_byte;
    assign data_push = (state == ST_WRITE) && byte_end && !first_byte && buf_in_ready;
    assign sample_now = byte_end && ((state == ST_ADDR && rx_shift[RW_BIT] && addr_match)
        || (state == ST_READ && read_mode));

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            state <= ST_IDLE;
        end else if (start_cond) begin
            state <= ST_ADDR;
        end else if (stop_cond) begin
            state <= ST_IDLE;
        end else begin
            case (state)
                ST_IDLE: state <= ST_IDLE;
                ST_ADDR: begin
                    if (byte_end) begin
                        state <= addr_match ? ST_ACK : ST_IDLE;
                    end
                end
                ST_WRITE: begin
                    if (byte_end) begin
                        state <= (first_byte || buf_in_ready) ? ST_ACK : ST_IDLE;
                    end
                end
                ST_READ: begin
                    if (byte_end) begin
                        state <= ST_MACK;
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        state <= read_mode ? ST_READ : ST_WRITE;
                    end
                end
                ST_MACK: begin
                    if (scl_fall) begin
                        state <= master_ack ? ST_READ : ST_IDLE;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            bit_cnt <= BIT_ZERO;
        end else if (start_cond) begin
            bit_cnt <= BIT_ZERO;
        end else if (scl_rise && (state == ST_ADDR || state == ST_WRITE || state == ST_READ)) begin
            bit_cnt <= bit_cnt + BIT_ONE;
        end else if (scl_fall && (state == ST_ACK || state == ST_MACK)) begin
            bit_cnt <= BIT_ZERO;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rx_shift <= LATCH_RST;
        end else if (scl_rise && (state == ST_ADDR || state == ST_WRITE)) begin
            rx_shift <= {rx_shift[MSB-1:0], sda_s};
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            read_mode <= 1'b0;
        end else if (state == ST_ADDR && byte_end) begin
            read_mode <= rx_shift[RW_BIT];
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            first_byte <= 1'b1;
        end else if (start_cond) begin
            first_byte <= 1'b1;
        end else if (dir_load) begin
            first_byte <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            master_ack <= 1'b0;
        end else if (state == ST_MACK && scl_rise) begin
            master_ack <= !sda_s;
        end
    end

    // ****************************************
    // Data line drive
    // ****************************************
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            tx_shift <= LATCH_RST;
        end else if (scl_fall && ((state == ST_ACK && read_mode) || (state == ST_MACK && master_ack))) begin
            tx_shift <= in_latch;
        end else if (scl_fall && state == ST_READ) begin
            tx_shift <= {tx_shift[MSB-1:0], 1'b1};
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            sda_oe <= 1'b0;
        end else if (start_cond || stop_cond) begin
            sda_oe <= 1'b0;
        end else if (scl_fall) begin
            case (state)
                ST_ADDR: sda_oe <= (bit_cnt == BYTE_DONE) && addr_match;
                ST_WRITE: sda_oe <= (bit_cnt == BYTE_DONE) && (first_byte || buf_in_ready);
                ST_READ: sda_oe <= (bit_cnt != BYTE_DONE) && !tx_shift[MSB-1];
                ST_ACK: sda_oe <= read_mode && !in_latch[MSB];
                ST_MACK: sda_oe <= master_ack && !in_latch[MSB];
                default: sda_oe <= 1'b0;
            endcase
        end
    end

    assign sda_out = 1'b0;

    // ****************************************
    // Latches
    // ****************************************
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            dir_latch <= LATCH_RST;
        end else if (dir_load) begin
            dir_latch <= rx_shift;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            in_latch <= LATCH_RST;
        end else if (sample_now) begin
            in_latch <= pin_view;
        end
    end

    ioex_pair_buf u_buf (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .in_valid(data_push),
        .in_ready(buf_in_ready),
        .in_data(rx_shift),
        .out_valid(buf_out_valid),
        .out_ready(buf_out_ready),
        .out_data(buf_out_data)
    );

    assign buf_out_ready = !latch_hold;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            out_latch <= LATCH_RST;
        end else if (buf_out_valid && buf_out_ready) begin
            out_latch <= buf_out_data;
        end
    end

    assign port_pin_out = out_latch;
    assign port_pin_oe = dir_latch;
    assign busy = (state != ST_IDLE);

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!nrst);

    chk_addr_mismatch: assert property (
        (state == ST_ADDR && byte_end && !start_cond && !stop_cond && !addr_match)
        |=> (state == ST_IDLE) && !sda_oe)
    else $error("Mismatched address not ignored");

    chk_addr_ack: assert property (
        (state == ST_ADDR && byte_end && !start_cond && !stop_cond && addr_match)
        |=> sda_oe && (state == ST_ACK))
    else $error("Matching address not acknowledged");

    chk_sel_compare: assert property (
        (state == ST_ADDR && byte_end && rx_shift[SEL_MSB:SEL_LSB] != sel_s) |-> !addr_match)
    else $error("Select pins compared in wrong order");

    chk_dir_first: assert property (
        dir_load |=> (dir_latch == $past(rx_shift)) && !first_byte)
    else $error("Direction byte not loaded");

    chk_dir_hold: assert property (
        $changed(dir_latch) |-> $past(dir_load))
    else $error("Direction changed without a direction byte");

    chk_out_after_byte: assert property (
        $changed(out_latch) |-> $past(buf_out_valid && !latch_hold))
    else $error("Output latch changed before a full byte");

    chk_push_reaches_out: assert property (
        (data_push && !buf_out_valid && !latch_hold) |=> ##1 (out_latch == $past(rx_shift, 2)))
    else $error("Written byte did not reach output latch");

    chk_in_sample: assert property (
        sample_now |=> (in_latch == $past(pin_view)))
    else $error("Input latch not sampled on eighth fall");

    chk_in_only_sample: assert property (
        $changed(in_latch) |-> $past(sample_now))
    else $error("Input latch changed outside a sample");

    chk_start_frame: assert property (
        start_cond |=> (state == ST_ADDR) && (bit_cnt == BIT_ZERO) && !sda_oe)
    else $error("Start did not reset framing");

    chk_stop_release: assert property (
        (stop_cond && !start_cond) |=> (state == ST_IDLE) && !sda_oe)
    else $error("Stop did not end transaction");

    chk_pin_drive: assert property (
        ($changed(out_latch) && !$past(dir_load)) |-> $stable(port_pin_oe))
    else $error("Input pin driven after data write");

    cov_addr_ack: cover property (state == ST_ADDR && byte_end && addr_match);
    cov_dir_load: cover property (dir_load);
    cov_out_update: cover property (data_push ##[1:20] $changed(out_latch));
    cov_read_two: cover property (sample_now ##[1:1000] sample_now);
endmodule : ioex_expander

// [ioex_master_model.sv]
`timescale 1ns/1ps
// ****************************************
// Serial bus master model
// ****************************************
module ioex_master_model (
    output logic scl,
    output logic sda_low,
    input wire logic sda_line
);
    localparam int QTR = 16;

    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    task automatic send_bit(input logic b);
        #QTR sda_low = !b;
        #QTR scl = 1'b1;
        #(2*QTR) scl = 1'b0;
    endtask : send_bit

    task automatic get_bit(output logic b);
        #QTR sda_low = 1'b0;
        #QTR scl = 1'b1;
        #QTR b = sda_line;
        #QTR scl = 1'b0;
    endtask : get_bit

    task automatic start_cond();
        #QTR sda_low = 1'b0;
        #QTR scl = 1'b1;
        #QTR sda_low = 1'b1;
        #QTR scl = 1'b0;
    endtask : start_cond

    task automatic stop_cond();
        #QTR sda_low = 1'b1;
        #QTR scl = 1'b1;
        #QTR sda_low = 1'b0;
        #(2*QTR);
    endtask : stop_cond

    task automatic wr_byte(input logic [7:0] d, output logic acked);
        logic a;
        for (int i = 7; i >= 0; i--) begin
            send_bit(d[i]);
        end
        get_bit(a);
        acked = !a;
    endtask : wr_byte

    task automatic rd_byte(input logic ack, output logic [7:0] d);
        logic b;
        for (int i = 7; i >= 0; i--) begin
            get_bit(b);
            d[i] = b;
        end
        send_bit(!ack);
    endtask : rd_byte
endmodule : ioex_master_model

// [testbench.sv]
`timescale 1ns/1ps
module testbench
    import ioex_pkg::*;
;
    localparam logic [3:0] AH = 4'h4;
    localparam logic [2:0] SEL = 3'b011;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic latch_hold = 1'b0;
    logic [7:0] ext_in = 8'h00;
    logic sda_out, sda_oe, busy, m_scl, m_low, sda_line, ack, bit_v;
    logic [7:0] port_pin_out, port_pin_oe, dir_latch, in_latch, pin_level, rd;
    int errors = 0;
    int total_checks = 0;

    // ****************************************
    // Clock, wiring and instances
    // ****************************************
    initial begin
        forever #2.5 ref_clk = !ref_clk;
    end
    assign sda_line = !((sda_oe && !sda_out) || m_low);
    assign pin_level = (port_pin_oe & port_pin_out) | (~port_pin_oe & ext_in);

    ioex_master_model i_ioex_master_model (.scl(m_scl), .sda_low(m_low), .sda_line(sda_line));
    ioex_expander #(.ADDR_HIGH(AH)) i_ioex_expander (
        .ref_clk(ref_clk), .nrst(nrst), .scl_in(m_scl), .sda_in(sda_line), .sda_out(sda_out),
        .sda_oe(sda_oe), .addr_select_pin_0(SEL[0]), .addr_select_pin_1(SEL[1]),
        .addr_select_pin_2(SEL[2]), .port_pin_in(pin_level), .port_pin_out(port_pin_out),
        .port_pin_oe(port_pin_oe), .latch_hold(latch_hold), .dir_latch(dir_latch),
        .in_latch(in_latch), .busy(busy)
    );

    // ****************************************
    // Compare and report
    // ****************************************
    task automatic check8(input logic [7:0] got, input logic [7:0] exp, input string msg);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : check8

    task automatic check1(input logic got, input logic exp, input string msg);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t %s got %b exp %b", $time, msg, got, exp);
        end
    endtask : check1

    task automatic summarize();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : summarize

    task automatic settle();
        repeat (8) @(negedge ref_clk);
    endtask : settle

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset();
        check8(dir_latch, 8'h00, "dir reset");
        check8(port_pin_oe, 8'h00, "oe reset");
        check8(port_pin_out, 8'h00, "out reset");
        check8(in_latch, 8'h00, "in reset");
        check1(sda_oe, 1'b0, "sda reset");
        check1(busy, 1'b0, "busy reset");
    endtask : t_reset

    task automatic t_addr();
        logic [7:0] a [4] = '{{AH, 3'b110, 1'b0}, {AH, 3'b010, 1'b0}, {4'h5, SEL, 1'b0}, {AH, SEL, 1'b0}};
        for (int i = 0; i < 4; i++) begin
            i_ioex_master_model.start_cond();
            i_ioex_master_model.wr_byte(a[i], ack);
            check1(ack, i == 3, "address ack");
            i_ioex_master_model.stop_cond();
        end
    endtask : t_addr

    task automatic t_write();
        logic [7:0] d = 8'hA5;
        i_ioex_master_model.start_cond();
        i_ioex_master_model.wr_byte({AH, SEL, 1'b0}, ack);
        i_ioex_master_model.wr_byte(8'hF0, ack);
        check1(ack, 1'b1, "dir ack");
        settle();
        check8(port_pin_oe, 8'hF0, "oe after dir");
        check8(port_pin_out, 8'h00, "low before data");
        for (int i = 7; i > 0; i--) begin
            i_ioex_master_model.send_bit(d[i]);
        end
        check8(port_pin_out, 8'h00, "partial byte");
        i_ioex_master_model.send_bit(d[0]);
        i_ioex_master_model.get_bit(bit_v);
        settle();
        check8(port_pin_out, 8'hA5, "first data");
        i_ioex_master_model.wr_byte(8'h3C, ack);
        settle();
        check8(port_pin_out, 8'h3C, "second data");
        check8(port_pin_oe, 8'hF0, "inputs stay");
        i_ioex_master_model.stop_cond();
    endtask : t_write

    task automatic t_read();
        @(negedge ref_clk) ext_in = 8'h5A;
        i_ioex_master_model.start_cond();
        i_ioex_master_model.wr_byte({AH, SEL, 1'b1}, ack);
        check1(ack, 1'b1, "read address ack");
        for (int i = 7; i > 0; i--) begin
            i_ioex_master_model.get_bit(bit_v);
            rd[i] = bit_v;
        end
        check8(in_latch, 8'h3A, "in latch");
        @(negedge ref_clk) ext_in = 8'h0F;
        i_ioex_master_model.get_bit(bit_v);
        rd[0] = bit_v;
        i_ioex_master_model.send_bit(1'b0);
        check8(rd, 8'h3A, "mixed read");
        i_ioex_master_model.rd_byte(1'b0, rd);
        check8(rd, 8'h3F, "fresh sample");
        i_ioex_master_model.stop_cond();
        settle();
        check8(dir_latch, 8'hF0, "dir kept");
        check1(busy, 1'b0, "idle after stop");
    endtask : t_read

    task automatic t_inputs();
        i_ioex_master_model.start_cond();
        i_ioex_master_model.wr_byte({AH, SEL, 1'b0}, ack);
        i_ioex_master_model.wr_byte(8'h00, ack);
        i_ioex_master_model.stop_cond();
        settle();
        check8(port_pin_oe, 8'h00, "all high impedance");
        @(negedge ref_clk) ext_in = 8'hC3;
        i_ioex_master_model.start_cond();
        i_ioex_master_model.wr_byte({AH, SEL, 1'b1}, ack);
        i_ioex_master_model.rd_byte(1'b0, rd);
        check8(rd, 8'hC3, "input read");
        i_ioex_master_model.stop_cond();
    endtask : t_inputs

    task automatic t_hold();
        @(negedge ref_clk) latch_hold = 1'b1;
        i_ioex_master_model.start_cond();
        i_ioex_master_model.wr_byte({AH, SEL, 1'b0}, ack);
        i_ioex_master_model.wr_byte(8'hFF, ack);
        i_ioex_master_model.wr_byte(8'h11, ack);
        check1(ack, 1'b1, "buffer one");
        i_ioex_master_model.wr_byte(8'h22, ack);
        check1(ack, 1'b1, "buffer two");
        i_ioex_master_model.wr_byte(8'h33, ack);
        check1(ack, 1'b0, "buffer full nack");
        check8(port_pin_out, 8'h3C, "held output");
        i_ioex_master_model.stop_cond();
        @(negedge ref_clk) latch_hold = 1'b0;
        settle();
        check8(port_pin_out, 8'h22, "drained in order");
    endtask : t_hold

    task automatic t_restart();
        i_ioex_master_model.start_cond();
        i_ioex_master_model.wr_byte({AH, SEL, 1'b0}, ack);
        i_ioex_master_model.wr_byte(8'h0F, ack);
        for (int i = 0; i < 4; i++) begin
            i_ioex_master_model.send_bit(1'b1);
        end
        i_ioex_master_model.start_cond();
        i_ioex_master_model.wr_byte({AH, SEL, 1'b0}, ack);
        check1(ack, 1'b1, "framing reset");
        i_ioex_master_model.wr_byte(8'h0F, ack);
        i_ioex_master_model.wr_byte(8'h81, ack);
        settle();
        check8(port_pin_out, 8'h81, "data after restart");
        check8(port_pin_oe, 8'h0F, "dir after restart");
        i_ioex_master_model.stop_cond();
        settle();
        check1(busy, 1'b0, "stop ends");
    endtask : t_restart

    // ****************************************
    // Main sequence and watchdog
    // ****************************************
    initial begin
        repeat (5) @(posedge ref_clk);
        @(negedge ref_clk) nrst = 1'b1;
        settle();
        t_reset();
        t_addr();
        t_write();
        t_read();
        t_inputs();
        t_hold();
        t_restart();
        summarize();
    end

    initial begin
        #200000;
        errors++;
        summarize();
    end
endmodule : testbench
